//--- tplc_params.svh
`ifndef TPLC_PARAMS_SVH
`define TPLC_PARAMS_SVH
// ****************************************
// clock and timing
// ****************************************
`define TPLC_CLK_MHZ      125
`define TPLC_CLK_KHZ      125000
`define TPLC_BIT_NS       100
`define TPLC_COL_BITS     2
`define TPLC_RST_HOLD_US  10
`define TPLC_JAB_MS       50
`define TPLC_UNJAB_MS     500
`define TPLC_LOSS_MS      100
// ****************************************
// field values
// ****************************************
`define TPLC_PORT_TP      2'h1
`define TPLC_BEATS_PASS   3'h5
`define TPLC_CNT_W        27
`endif

//--- tplc_pkg.sv
package tplc_pkg;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    TPLC_PD   = 2'h0,
    TPLC_HOLD = 2'h1,
    TPLC_FAIL = 2'h3,
    TPLC_PASS = 2'h2
  } tplc_link_t;

  typedef enum logic [1:0] {
    TPLC_WAKE_ON_LINK_ENABLE = 2'h0,
    TPLC_WGNT  = 2'h1,
    TPLC_SRST  = 2'h3,
    TPLC_SLEEP = 2'h2
  } tplc_slp_t;
endpackage

//--- tplc_link_power_ctrl.sv
`include "tplc_params.svh"
module tplc_link_power_ctrl #(
  parameter int JAB_CYC   = `TPLC_JAB_MS * `TPLC_CLK_KHZ,
  parameter int UNJAB_CYC = `TPLC_UNJAB_MS * `TPLC_CLK_KHZ,
  parameter int LOSS_CYC  = `TPLC_LOSS_MS * `TPLC_CLK_KHZ
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // configuration
  input  wire logic [1:0] port_select_field,
  input  wire logic       wake_on_link_enable,
  input  wire logic       link_led_enable,
  input  wire logic       link_test_disable,
  // pins from outside
  input  wire logic       sleep_n,
  input  wire logic       gnt_n,
  input  wire logic       rx_line_active,
  input  wire logic       rx_link_beat,
  // internal sources
  input  wire logic       rx_frame_ok,
  input  wire logic       rx_pol_reversed,
  input  wire logic       tx_request,
  input  wire logic       tx_data,
  input  wire logic       dma_req,
  input  wire logic       io_access,
  input  wire logic       flag_clear,
  // medium side
  output logic            tp_tx_data,
  output logic            tp_tx_enable,
  output logic            link_beat_enable,
  output logic            receive_enable,
  // status
  output logic            transmit_activity,
  output logic            receive_activity,
  output logic            collision,
  output logic            link_good_output,
  output logic            receive_polarity_status,
  output logic            sqe_test_enable,
  output logic            lost_carrier_flag,
  output logic            collision_error_flag,
  output logic            jabber_flag,
  // host bus and sleep
  output logic            req_n,
  output logic            io_target_abort,
  output logic            soft_reset,
  output logic            coma_active,
  output logic            snooze_active
);
  localparam int CW = `TPLC_CNT_W;
  localparam int HOLD_CYC = `TPLC_RST_HOLD_US * `TPLC_CLK_MHZ;
  localparam int COL_CYC =
    (`TPLC_COL_BITS * `TPLC_BIT_NS * `TPLC_CLK_MHZ + 999) / 1000;

  // ****************************************
  // synchronisers
  // ****************************************
  logic [1:0] slp_q, gnt_q, rxa_q, beat_q;
  logic       beat_d1_q;
  always_ff @(posedge clk_sys) begin
    slp_q     <= {slp_q[0], sleep_n};
    gnt_q     <= {gnt_q[0], gnt_n};
    rxa_q     <= {rxa_q[0], rx_line_active};
    beat_q    <= {beat_q[0], rx_link_beat};
    beat_d1_q <= beat_q[1];
  end
  wire sleep_req = ~slp_q[1];
  wire granted   = ~gnt_q[1];
  wire rx_act    = rxa_q[1];
  wire beat_rise = beat_q[1] & ~beat_d1_q;

  // ****************************************
  // sleep sequencing
  // ****************************************
  tplc_pkg::tplc_slp_t slp_q_st, slp_d;
  logic req_q;
  wire  asleep = slp_q_st == tplc_pkg::TPLC_SLEEP;
  always_comb begin
    slp_d = slp_q_st;
    case (slp_q_st)
      tplc_pkg::TPLC_WAKE_ON_LINK_ENABLE: begin
        if (sleep_req)
          slp_d = req_q ? tplc_pkg::TPLC_WGNT : tplc_pkg::TPLC_SRST;
      end
      tplc_pkg::TPLC_WGNT: begin
        if (granted)
          slp_d = tplc_pkg::TPLC_SRST;
      end
      tplc_pkg::TPLC_SRST: slp_d = tplc_pkg::TPLC_SLEEP;
      tplc_pkg::TPLC_SLEEP: begin
        if (!sleep_req)
          slp_d = tplc_pkg::TPLC_WAKE_ON_LINK_ENABLE;
      end
      default: slp_d = tplc_pkg::TPLC_WAKE_ON_LINK_ENABLE;
    endcase
  end
  // request held through the grant wait, dropped on leaving it
  wire req_d = (slp_q_st == tplc_pkg::TPLC_WAKE_ON_LINK_ENABLE) ? (sleep_req ? req_q : dma_req) :
               (slp_q_st == tplc_pkg::TPLC_WGNT && !granted);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slp_q_st <= tplc_pkg::TPLC_WAKE_ON_LINK_ENABLE;
      req_q    <= 1'b0;
    end else begin
      slp_q_st <= slp_d;
      req_q    <= req_d;
    end
  end

  // ****************************************
  // power-down conditions
  // ****************************************
  logic tp_sel_q;
  wire  tp_sel = port_select_field == `TPLC_PORT_TP;
  wire  coma   = asleep & ~wake_on_link_enable;
  wire  snooze = asleep & wake_on_link_enable & tp_sel;
  // non-tp snooze falls back to power-down
  wire  pd     = coma | ~tp_sel | (asleep & ~snooze);
  wire  to_tp  = tp_sel & ~tp_sel_q;

  // ****************************************
  // link state
  // ****************************************
  tplc_pkg::tplc_link_t lk_q, lk_d;
  logic [CW-1:0] lcnt_q, lcnt_d;
  logic [2:0]    beats_q, beats_d;
  wire hold_done = lcnt_q >= CW'(HOLD_CYC - 1);
  wire rx_seen   = beat_rise | rx_frame_ok | rx_act;
  wire lost      = lcnt_q >= CW'(LOSS_CYC - 1);
  always_comb begin
    lk_d    = lk_q;
    lcnt_d  = lcnt_q + CW'(1);
    beats_d = beats_q;
    case (lk_q)
      tplc_pkg::TPLC_PD: begin
        lcnt_d = '0;
        if (!pd)
          lk_d = tplc_pkg::TPLC_HOLD;
      end
      tplc_pkg::TPLC_HOLD: begin
        if (hold_done) begin
          lk_d   = tplc_pkg::TPLC_FAIL;
          lcnt_d = '0;
        end
      end
      tplc_pkg::TPLC_FAIL: begin
        lcnt_d = '0;
        if (beat_rise)
          beats_d = beats_q + 3'h1;
        if (rx_frame_ok || link_test_disable ||
            (beat_rise && beats_q == `TPLC_BEATS_PASS - 3'h1)) begin
          lk_d    = tplc_pkg::TPLC_PASS;
          beats_d = '0;
        end
      end
      tplc_pkg::TPLC_PASS: begin
        if (rx_seen || link_test_disable)
          lcnt_d = '0;
        else if (lost)
          lk_d = tplc_pkg::TPLC_FAIL;
      end
      default: lk_d = tplc_pkg::TPLC_PD;
    endcase
    if (to_tp && lk_d == tplc_pkg::TPLC_PASS)
      lk_d = tplc_pkg::TPLC_FAIL;
    if (pd) begin
      lk_d    = tplc_pkg::TPLC_PD;
      beats_d = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lk_q     <= tplc_pkg::TPLC_PD;
      lcnt_q   <= '0;
      beats_q  <= '0;
      tp_sel_q <= 1'b0;
    end else begin
      lk_q     <= lk_d;
      lcnt_q   <= lcnt_d;
      beats_q  <= beats_d;
      tp_sel_q <= tp_sel;
    end
  end
  wire pass = lk_q == tplc_pkg::TPLC_PASS;
  wire fail = lk_q == tplc_pkg::TPLC_FAIL;

  // ****************************************
  // jabber
  // ****************************************
  logic          jab_q, tx_prev_q;
  logic [CW-1:0] jcnt_q;
  wire jab_trip = pass & ~jab_q & tx_request &
                  (jcnt_q >= CW'(JAB_CYC - 1));
  // unjab restarts if transmit returns before it expires
  wire unjab    = jab_q & ~tx_request &
                  (jcnt_q >= CW'(UNJAB_CYC - 1));
  wire [CW-1:0] jcnt_d =
    (jab_trip | unjab | ~pass) ? '0 :
    (jab_q ? (tx_request ? '0 : jcnt_q + CW'(1)) :
     (tx_request ? jcnt_q + CW'(1) : '0));
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      jab_q     <= 1'b0;
      jcnt_q    <= '0;
      tx_prev_q <= 1'b0;
    end else begin
      jab_q     <= pass & ((jab_q & ~unjab) | jab_trip);
      jcnt_q    <= jcnt_d;
      tx_prev_q <= tx_request;
    end
  end

  // ****************************************
  // collision stretch
  // ****************************************
  logic [4:0] ccnt_q;
  wire col_raw = pass & tx_request & rx_act;
  wire [4:0] ccnt_d = col_raw ? 5'(COL_CYC) :
                      (ccnt_q != 5'h0 ? ccnt_q - 5'h1 : 5'h0);
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      ccnt_q <= '0;
    else
      ccnt_q <= pass ? ccnt_d : 5'h0;
  end

  // ****************************************
  // status and medium outputs
  // ****************************************
  // snooze blanks the activity and collision leds; link good stays lit only with link_led_enable
  wire act_ok   = pass & ~snooze;
  wire drive    = act_ok & tx_request & ~jab_q;
  wire fail_tx  = fail & tx_request & ~tx_prev_q;
  wire col_d    = act_ok & (col_raw | ccnt_q != 5'h0 | jab_q);
  wire lgood_d  = pass & (~snooze | link_led_enable);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tp_tx_data              <= 1'b0;
      tp_tx_enable            <= 1'b0;
      link_beat_enable        <= 1'b0;
      receive_enable          <= 1'b0;
      transmit_activity       <= 1'b0;
      receive_activity        <= 1'b0;
      collision               <= 1'b0;
      link_good_output        <= 1'b0;
      receive_polarity_status <= 1'b0;
      sqe_test_enable         <= 1'b0;
      lost_carrier_flag       <= 1'b0;
      collision_error_flag    <= 1'b0;
      jabber_flag             <= 1'b0;
    end else begin
      tp_tx_data              <= drive & tx_data;
      tp_tx_enable            <= drive;
      link_beat_enable        <= ~pd & ~snooze & ~tx_request;
      receive_enable          <= ~pd;
      transmit_activity       <= drive;
      receive_activity        <= act_ok & rx_act;
      collision               <= col_d;
      link_good_output        <= lgood_d;
      receive_polarity_status <= ~pd & rx_pol_reversed;
      sqe_test_enable         <= ~tp_sel;
      // a new event beats a clear in the same cycle
      lost_carrier_flag       <= fail_tx | (lost_carrier_flag & ~flag_clear);
      collision_error_flag    <= fail_tx | (collision_error_flag & ~flag_clear);
      jabber_flag             <= jab_trip | (jabber_flag & ~flag_clear);
    end
  end

  // ****************************************
  // host side
  // ****************************************
  // sleep is sampled only after reset; the system keeps it off at power-up
  logic sr_q, coma_q, snz_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sr_q   <= 1'b0;
      coma_q <= 1'b0;
      snz_q  <= 1'b0;
    end else begin
      sr_q   <= slp_d == tplc_pkg::TPLC_SRST;
      coma_q <= coma;
      snz_q  <= snooze;
    end
  end
  assign req_n           = ~req_q;
  assign io_target_abort = io_access & (asleep | sleep_req);
  assign soft_reset      = sr_q;
  assign coma_active     = coma_q;
  assign snooze_active   = snz_q;
endmodule

//--- tplc_chk_asserts.sv
module tplc_chk #(
  parameter int JAB_CYC   = 200,
  parameter int UNJAB_CYC = 400,
  parameter int LOSS_CYC  = 3000
) (
  // clock and inputs
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [1:0] port_select_field,
  input wire logic       link_led_enable,
  input wire logic       io_access,
  // outputs
  input wire logic       tp_tx_data,
  input wire logic       tp_tx_enable,
  input wire logic       link_beat_enable,
  input wire logic       receive_enable,
  input wire logic       transmit_activity,
  input wire logic       receive_activity,
  input wire logic       collision,
  input wire logic       link_good_output,
  input wire logic       receive_polarity_status,
  input wire logic       sqe_test_enable,
  input wire logic       jabber_flag,
  input wire logic       req_n,
  input wire logic       io_target_abort,
  input wire logic       soft_reset,
  input wire logic       coma_active,
  input wire logic       snooze_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_sqe_port: assert property (!$past(sys_rst) && $stable(port_select_field) |->
    sqe_test_enable == (port_select_field != 2'h1)) else $error("sqe mismatch");
  a_pd_quiet: assert property ((port_select_field != 2'h1) [*3] |-> !tp_tx_enable && !tp_tx_data
    && !link_good_output && !receive_polarity_status && !transmit_activity && !receive_activity
    && !collision) else $error("power-down not quiet");
  a_fail_quiet: assert property ((transmit_activity || receive_activity || tp_tx_enable)
    |-> link_good_output) else $error("activity without link");
  a_col_hold: assert property ($rose(collision) && $stable(port_select_field) |=> collision [*8])
    else $error("collision too short");
  a_jab_stop: assert property ($rose(jabber_flag) |-> ##[0:2] (collision && !tp_tx_enable) [*8])
    else $error("jabber not handled");
  a_sleep_seq: assert property (soft_reset |-> req_n ##1 !soft_reset ##[0:2] (coma_active || snooze_active))
    else $error("sleep entry order");
  a_coma_off: assert property (coma_active [*2] |-> !snooze_active && !receive_enable && !link_good_output)
    else $error("coma not powered down");
  a_snooze_leds: assert property (snooze_active [*2] |-> receive_enable && !link_beat_enable
    && !transmit_activity && !collision) else $error("snooze outputs wrong");
  a_snooze_led_en: assert property (snooze_active && !link_led_enable && !$past(link_led_enable)
    |-> !link_good_output) else $error("link led without enable");
  a_io_abort: assert property ((coma_active || snooze_active) && io_access |-> io_target_abort)
    else $error("io access not aborted");
endmodule
bind tplc_link_power_ctrl tplc_chk #(.JAB_CYC(JAB_CYC), .UNJAB_CYC(UNJAB_CYC), .LOSS_CYC(LOSS_CYC)) tplc_chk_i (
  .clk_sys, .sys_rst, .port_select_field, .link_led_enable, .io_access, .tp_tx_data, .tp_tx_enable,
  .link_beat_enable, .receive_enable, .transmit_activity, .receive_activity, .collision, .link_good_output,
  .receive_polarity_status, .sqe_test_enable, .jabber_flag, .req_n, .io_target_abort, .soft_reset,
  .coma_active, .snooze_active);

//--- tplc_medium_model.sv
module tplc_medium_model #(
  parameter int GNT_DLY = 20
) (
  // clock
  input  wire logic clk_sys,
  // stimulus and bus request
  input  wire logic beat_go,
  input  wire logic req_n,
  // far-side pins
  output logic      rx_link_beat,
  output logic      gnt_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q = 3'h0;
  int         wait_q = 0;
  // one beat per eight-cycle slot, so the bench counts beats by slots
  always @(posedge clk_sys) begin
    ph_q <= beat_go ? ph_q + 3'h1 : 3'h0;
    wait_q <= (req_n !== 1'b0) ? 0 : wait_q + 1;
  end
  assign rx_link_beat = beat_go && (ph_q < 3'h2);
  // slow arbiter, withdraws grant as soon as request drops
  assign gnt_n = (req_n !== 1'b0) || (wait_q < GNT_DLY);
endmodule

//--- tb_tplc_link_power_ctrl.sv
module tb_tplc_link_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int JABBER_FLAG = 200;
  localparam int UNJAB = 400;
  localparam int LOSS = 3000;
  logic       clk_sys = 1'b0, sys_rst = 1'b1, sleep_n = 1'b1, beat_go = 1'b0;
  logic [1:0] port_select_field = 2'h1;
  logic       wake_on_link_enable = 1'b0, link_led_enable = 1'b0, link_test_disable = 1'b0;
  logic       rx_line_active = 1'b0, rx_frame_ok = 1'b0, rx_pol_reversed = 1'b0, tx_request = 1'b0;
  logic       tx_data = 1'b0, dma_req = 1'b0, io_access = 1'b0, flag_clear = 1'b0;
  wire logic  rx_link_beat, gnt_n, tp_tx_data, tp_tx_enable, link_beat_enable, receive_enable;
  wire logic  transmit_activity, receive_activity, collision, link_good_output, receive_polarity_status;
  wire logic  sqe_test_enable, lost_carrier_flag, collision_error_flag, jabber_flag, req_n;
  wire logic  io_target_abort, soft_reset, coma_active, snooze_active;
  int         bad_count = 0, cmp_count = 0, n;
  always #4 clk_sys = ~clk_sys;
  tplc_link_power_ctrl #(.JAB_CYC(JABBER_FLAG), .UNJAB_CYC(UNJAB), .LOSS_CYC(LOSS)) tplc_link_power_ctrl_i (.*);
  tplc_medium_model tplc_medium_model_i (.clk_sys, .beat_go, .req_n, .rx_link_beat, .gnt_n);
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic exp_link(input int beats, input logic frame);
    return (beats >= 5) || frame;
  endfunction
  // fourth beat alone must not bring the link up
  task automatic link_up;
    beat_go = 1'b1;
    step(28);
    chk(link_good_output, exp_link(4, 1'b0));
    step(12);
    chk(link_good_output, exp_link(5, 1'b0));
    beat_go = 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    bad_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'hb5a88ef0));
    step(10);
    sys_rst = 1'b0;
    step(1200);
    chk(link_good_output, 1'b0);
    step(60);
    tx_request = 1'b1;
    step(3);
    chk({tp_tx_enable, transmit_activity, lost_carrier_flag, collision_error_flag}, 4'h3);
    tx_request = 1'b0;
    flag_clear = 1'b1;
    step(1);
    flag_clear = 1'b0;
    chk({lost_carrier_flag, collision_error_flag}, 2'h0);
    link_up;
    repeat (6) begin
      tx_request = 1'b1;
      tx_data = 1'($urandom);
      rx_pol_reversed = 1'($urandom);
      rx_line_active = 1'b1;
      step(30 + $urandom % 20);
      chk({transmit_activity, receive_activity, collision, tp_tx_enable}, 4'hf);
      chk({tp_tx_data, receive_polarity_status}, {tx_data, rx_pol_reversed});
      rx_line_active = 1'b0;
      step(20);
      chk(collision, 1'b1);
      step(14);
      chk(collision, 1'b0);
      tx_request = 1'b0;
      step(5 + $urandom % 10);
    end
    tx_request = 1'b1;
    step(JABBER_FLAG + 10);
    chk({jabber_flag, collision, tp_tx_enable}, 3'h6);
    tx_request = 1'b0;
    step(UNJAB - 20);
    chk({collision, tp_tx_enable}, 2'h2);
    step(60);
    chk(collision, 1'b0);
    flag_clear = 1'b1;
    step(1);
    flag_clear = 1'b0;
    chk(jabber_flag, 1'b0);
    for (int p = 0; p < 4; p++) begin
      port_select_field = p[1:0];
      step(4);
      chk(sqe_test_enable, p != 1);
      chk(link_good_output, 1'b0);
    end
    port_select_field = 2'h1;
    step(1260);
    chk(link_good_output, 1'b0);
    rx_frame_ok = 1'b1;
    step(1);
    rx_frame_ok = 1'b0;
    step(3);
    chk(link_good_output, exp_link(0, 1'b1));
    step(LOSS - 10);
    chk(link_good_output, 1'b1);
    step(10);
    chk(link_good_output, 1'b0);
    link_test_disable = 1'b1;
    step(3);
    chk(link_good_output, 1'b1);
    link_test_disable = 1'b0;
    dma_req = 1'b1;
    step(2);
    chk(req_n, 1'b0);
    sleep_n = 1'b0;
    n = 0;
    while (soft_reset !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    dma_req = 1'b0;
    chk({req_n, n >= 20}, 2'h3);
    step(4);
    io_access = 1'b1;
    step(1);
    chk({coma_active, snooze_active, io_target_abort}, 3'h5);
    io_access = 1'b0;
    sleep_n = 1'b1;
    wake_on_link_enable = 1'b1;
    step(1270);
    sleep_n = 1'b0;
    step(12);
    chk({snooze_active, link_good_output, link_beat_enable, receive_enable}, 4'h9);
    link_led_enable = 1'b1;
    link_up;
    test_done;
  end
endmodule
